// ==== logic/nand_ctl_defs.svh ====
// Constants for the NAND identification and readiness controller
`ifndef NAND_CTL_DEFS_SVH
`define NAND_CTL_DEFS_SVH
`define CMD_RESET        8'hff
`define CMD_SET_FEATURE  8'hef
`define CMD_READ_ID      8'h90
`define CMD_STATUS       8'h70
`define CMD_STATUS_ALT   8'hf1
`define FEAT_DRIVE_ADDR  8'h10
`define ID_ADDR_MAKER    8'h00
`define ID_ADDR_SIG      8'h40
`define DRIVE_REDUCED    8'h02
`define DRIVE_NOMINAL    8'h04
`define DRIVE_INCREASED  8'h06
`define ID_BYTES         3'd6
`define FEAT_BYTES       2'd3
`define STAT_READY_BIT   6
`define STAT_WP_BIT      7
`define RST_BUSY_MS      5
`define CLK_MHZ          100
`define RST_BUSY_CYC     (`RST_BUSY_MS * 1000 * `CLK_MHZ)
`define STROBE_CYC       4'd3
`define RB_SETTLE_CYC    32'd4
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_DRIVE        12'h008
`define REG_ID_LO        12'h00c
`define REG_ID_HI        12'h010
`define REG_NAND_STAT    12'h014
`define CTRL_GO_BIT      0
`define CTRL_OP_LSB      1
`define CTRL_WP_BIT      4
`define CTRL_ADDR_LSB    8
`define STS_BUSY_BIT     0
`define STS_INIT_BIT     1
`define STS_RB_BIT       2
`define STS_ERR_BIT      3
`define STS_TMO_BIT      4
`define OP_RESET         3'd0
`define OP_DRIVE         3'd1
`define OP_READ_ID       3'd2
`define OP_STATUS        3'd3
`endif

// ==== logic/nand_ctl_pkg.sv ====
// Types shared by the NAND controller files
`default_nettype none
package nand_ctl_pkg;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] dq_o;
    logic       dq_oe_n;
  } nand_out_t;
  typedef struct packed {
    logic [7:0] dq_i;
    logic       rb_n;
  } nand_in_t;
  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_WDATA, CYC_RDATA} cyc_kind_t;
endpackage : nand_ctl_pkg
`default_nettype wire

// ==== logic/nand_cycle.sv ====
// One strobed bus cycle on the NAND pins: command, address, write or read byte
`default_nettype none
`include "nand_ctl_defs.svh"
module nand_cycle (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Request
  input  wire logic                   start,
  input  wire nand_ctl_pkg::cyc_kind_t kind,
  input  wire logic [7:0]             wbyte,
  output logic                        done,
  output logic [7:0]                  rbyte_r,
  // Pins
  input  wire logic [7:0]             dq_i,
  output logic                        cle_r,
  output logic                        ale_r,
  output logic                        we_n_r,
  output logic                        re_n_r,
  output logic [7:0]                  dq_o_r,
  output logic                        dq_oe_n_r
);
  import nand_ctl_pkg::*;
  logic [3:0] cnt_r;
  logic       act_r;
  logic       rd_r;
  wire        last = act_r && (cnt_r == `STROBE_CYC);
  assign done = last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0; act_r <= 1'b0; rd_r <= 1'b0;
      cle_r <= 1'b0; ale_r <= 1'b0; we_n_r <= 1'b1; re_n_r <= 1'b1;
      dq_o_r <= 8'h00; dq_oe_n_r <= 1'b1; rbyte_r <= 8'h00;
    end else if (start && !act_r) begin
      act_r <= 1'b1; cnt_r <= 4'h0; rd_r <= (kind == CYC_RDATA);
      cle_r <= (kind == CYC_CMD); ale_r <= (kind == CYC_ADDR);
      we_n_r <= (kind == CYC_RDATA); re_n_r <= (kind != CYC_RDATA);
      dq_o_r <= wbyte; dq_oe_n_r <= (kind == CYC_RDATA);
    end else if (last) begin
      act_r <= 1'b0; we_n_r <= 1'b1; re_n_r <= 1'b1;
    end else if (act_r) begin
      cnt_r <= cnt_r + 4'h1;
      // Sample read data before the strobe rises, so it stands while done is high
      if (rd_r && cnt_r == (`STROBE_CYC - 4'h1)) rbyte_r <= dq_i;
    end else begin
      cle_r <= 1'b0; ale_r <= 1'b0; dq_oe_n_r <= 1'b1;
    end
  end
endmodule : nand_cycle
`default_nettype wire

// ==== logic/nand_id_ctl.sv ====
// APB-controlled host for NAND reset, drive feature, ID and status reads
//
// Our own choice: the APB interface to the registers.
`default_nettype none
`include "nand_ctl_defs.svh"
module nand_id_ctl #(
  parameter int RST_WAIT_CYC = `RST_BUSY_CYC
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // NAND pins
  input  wire nand_ctl_pkg::nand_in_t  nand_in,
  output nand_ctl_pkg::nand_out_t      nand_out
);
  import nand_ctl_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_DATA, S_WAIT, S_DONE} state_t;
  state_t     st_r, st_nxt;
  logic [2:0] op_r;
  logic [7:0] addr_r, drive_r, drive_req_r, stat_r;
  logic [47:0] id_r;
  logic [2:0] idx_r;
  logic       init_r, err_r, tmo_r, wp_n_r, ce_n_r;
  logic [31:0] wait_r;
  logic       cyc_start, cyc_done;
  cyc_kind_t  cyc_kind;
  logic [7:0] cyc_wbyte, cyc_rbyte;
  logic       cle, ale, we_n, re_n, oe_n;
  logic [7:0] dq_o;
  // APB decode
  wire        acc     = psel && penable;
  wire        wr      = acc && pwrite;
  wire        ctrl_wr = wr && (paddr == `REG_CTRL);
  wire        busy    = (st_r != S_IDLE);
  wire        rb_ready = nand_in.rb_n;
  wire [2:0]  req_op  = pwdata[`CTRL_OP_LSB +: 3];
  wire        known_addr = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                           (paddr == `REG_DRIVE) || (paddr == `REG_ID_LO) ||
                           (paddr == `REG_ID_HI) || (paddr == `REG_NAND_STAT);
  // Refuse anything but reset before init, and every operation while busy
  wire        go_ok = !busy && (init_r || req_op == `OP_RESET);
  wire        go    = ctrl_wr && pwdata[`CTRL_GO_BIT] && go_ok;
  wire        go_bad = ctrl_wr && pwdata[`CTRL_GO_BIT] && !go_ok;
  wire        legal_drive = (pwdata[7:0] == `DRIVE_REDUCED) || (pwdata[7:0] == `DRIVE_NOMINAL) ||
                            (pwdata[7:0] == `DRIVE_INCREASED);
  wire        wp_wr = ctrl_wr && !busy;
  wire        is_id = (op_r == `OP_READ_ID);
  wire        is_st = (op_r == `OP_STATUS);
  wire        is_dr = (op_r == `OP_DRIVE);
  wire        tmo_hit = (st_r == S_WAIT) && (wait_r >= 32'(RST_WAIT_CYC));
  assign pready  = 1'b1;
  assign pslverr = acc && !known_addr;
  assign prdata  = (paddr == `REG_CTRL)   ? {24'h0, 3'b0, wp_n_r, op_r, 1'b0} :
                   (paddr == `REG_STATUS) ? {27'h0, tmo_r, err_r, rb_ready, init_r, busy} :
                   (paddr == `REG_DRIVE)  ? {24'h0, drive_r} :
                   (paddr == `REG_ID_LO)  ? id_r[31:0] :
                   (paddr == `REG_ID_HI)  ? {16'h0, id_r[47:32]} :
                   (paddr == `REG_NAND_STAT) ? {24'h0, stat_r} : 32'h0;
  // Command byte per operation
  assign cyc_wbyte = (st_r == S_CMD)  ? ((op_r == `OP_RESET) ? `CMD_RESET :
                                         is_dr ? `CMD_SET_FEATURE :
                                         is_id ? `CMD_READ_ID : `CMD_STATUS) :
                     (st_r == S_ADDR) ? (is_dr ? `FEAT_DRIVE_ADDR : addr_r) :
                     (idx_r == 3'd0) ? drive_req_r : 8'h00;
  assign cyc_kind  = (st_r == S_CMD) ? CYC_CMD : (st_r == S_ADDR) ? CYC_ADDR :
                     is_dr ? CYC_WDATA : CYC_RDATA;
  assign cyc_start = (st_r == S_CMD) || (st_r == S_ADDR) || (st_r == S_DATA);
  wire [2:0] last_idx = is_id ? (`ID_BYTES - 3'd1) : is_dr ? {1'b0, `FEAT_BYTES} : 3'd0;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (go) st_nxt = S_CMD;
      S_CMD:  if (cyc_done) st_nxt = (op_r == `OP_RESET) ? S_WAIT : is_st ? S_DATA : S_ADDR;
      S_ADDR: if (cyc_done) st_nxt = is_id ? S_DATA : is_dr ? S_DATA : S_WAIT;
      S_DATA: if (cyc_done && idx_r == last_idx) st_nxt = is_dr ? S_WAIT : S_DONE;
      S_WAIT: if ((rb_ready && wait_r > `RB_SETTLE_CYC) || tmo_hit) st_nxt = S_DONE;
      S_DONE: st_nxt = S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= S_IDLE;
    else st_r <= st_nxt;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= `OP_RESET; addr_r <= 8'h00; drive_req_r <= `DRIVE_NOMINAL;
      wp_n_r <= 1'b0; ce_n_r <= 1'b1;
    end else begin
      if (go) begin
        op_r <= req_op; addr_r <= pwdata[`CTRL_ADDR_LSB +: 8];
      end
      if (wp_wr) wp_n_r <= pwdata[`CTRL_WP_BIT];
      if (wr && paddr == `REG_DRIVE && !busy && legal_drive) drive_req_r <= pwdata[7:0];
      ce_n_r <= !(busy || go);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 3'd0; wait_r <= 32'h0; id_r <= 48'h0; stat_r <= 8'h00;
      drive_r <= `DRIVE_NOMINAL; init_r <= 1'b0; err_r <= 1'b0; tmo_r <= 1'b0;
    end else begin
      if (st_r != S_DATA) idx_r <= 3'd0;
      else if (cyc_done) idx_r <= idx_r + 3'd1;
      if (st_r != S_WAIT) wait_r <= 32'h0;
      else wait_r <= wait_r + 32'h1;
      if (st_r == S_DATA && cyc_done && is_id)
        id_r[idx_r*8 +: 8] <= cyc_rbyte;
      if (st_r == S_DATA && cyc_done && is_st) stat_r <= cyc_rbyte;
      if (st_r == S_DONE && op_r == `OP_RESET && !tmo_r) init_r <= 1'b1;
      if (st_r == S_DONE && is_dr) drive_r <= drive_req_r;
      if (tmo_hit) tmo_r <= 1'b1;
      else if (go) tmo_r <= 1'b0;
      if (go_bad) err_r <= 1'b1;
      else if (go) err_r <= 1'b0;
    end
  end
  nand_cycle u_cycle (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (cyc_start),
    .kind      (cyc_kind),
    .wbyte     (cyc_wbyte),
    .done      (cyc_done),
    .rbyte_r   (cyc_rbyte),
    .dq_i      (nand_in.dq_i),
    .cle_r     (cle),
    .ale_r     (ale),
    .we_n_r    (we_n),
    .re_n_r    (re_n),
    .dq_o_r    (dq_o),
    .dq_oe_n_r (oe_n)
  );
  assign nand_out = '{ce_n: ce_n_r, cle: cle, ale: ale, we_n: we_n, re_n: re_n,
                      wp_n: wp_n_r, dq_o: dq_o, dq_oe_n: oe_n};
endmodule : nand_id_ctl
`default_nettype wire

// ==== testbench/nand_id_ctl_props.sv ====
// Checker for the NAND controller pin sequencing
`default_nettype none
module nand_id_ctl_props (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // Pins
  input wire nand_ctl_pkg::nand_in_t  nand_in,
  input wire nand_ctl_pkg::nand_out_t nand_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import nand_ctl_pkg::*;
  logic      we_q_r;
  logic      seen_r;
  logic      feat_r;
  wire logic wr_fall = we_q_r & ~nand_out.we_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_q_r <= 1'b1;
      seen_r <= 1'b0;
      feat_r <= 1'b0;
    end else begin
      we_q_r <= nand_out.we_n;
      if (wr_fall && nand_out.cle) seen_r <= 1'b1;
      if (wr_fall) feat_r <= nand_out.cle && nand_out.dq_o == 8'hef;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_feat_cmd;
    wr_fall && nand_out.cle && nand_out.dq_o == 8'hef;
  endsequence
  a_first_reset: assert property (wr_fall && nand_out.cle && !seen_r |-> nand_out.dq_o == 8'hff)
    else $error("first command is not reset");
  a_feat_addr: assert property (feat_r && wr_fall |-> nand_out.ale && nand_out.dq_o == 8'h10)
    else $error("feature address missing");
  a_feat_soon: assert property (s_feat_cmd |-> ##[1:40] (wr_fall && nand_out.ale))
    else $error("feature address late");
  a_wp_busy: assert property ($fell(nand_out.wp_n) |-> $past(nand_in.rb_n))
    else $error("protect asserted while busy");
  a_busy_quiet: assert property (!nand_in.rb_n |-> !wr_fall)
    else $error("command written while busy");
  a_hold_strobe: assert property (!nand_out.we_n && !$past(nand_out.we_n) |->
    $stable(nand_out.dq_o) && $stable(nand_out.cle) && $stable(nand_out.ale))
    else $error("byte changed under strobe");
  a_strobe_excl: assert property (nand_out.we_n || nand_out.re_n)
    else $error("both strobes low");
  a_read_release: assert property (!nand_out.re_n |-> nand_out.dq_oe_n && !nand_out.ce_n)
    else $error("host drives data during read");
  a_latch_excl: assert property (!(nand_out.cle && nand_out.ale))
    else $error("command and address latch together");
endmodule : nand_id_ctl_props
bind nand_id_ctl nand_id_ctl_props u_props (.pclk(pclk), .presetn(presetn),
  .nand_in(nand_in), .nand_out(nand_out));
`default_nettype wire

// ==== testbench/nand_dev_model.sv ====
// Behavioural NAND device for reset, drive feature, ID and status
`default_nettype none
module nand_dev_model #(
  parameter int          BUSY_CYC = 20,
  parameter logic [47:0] MAKER_ID = 48'ha1b2c3d4e5f6, // Arbitrary value
  parameter logic [47:0] SIG_ID   = 48'h5a6b7c8d9e0f  // Arbitrary value
) (
  // Busy timing clock
  input  wire logic                    pclk,
  // Pins
  input  wire nand_ctl_pkg::nand_out_t pins,
  output logic [7:0]                   dq,
  output logic                         rb_oe_n,
  output logic [7:0]                   drive_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import nand_ctl_pkg::*;
  logic [7:0] cmd_r  = 8'h00;
  logic [7:0] addr_r = 8'h00;
  logic [7:0] par_r  = 8'h00;
  int         nbyte  = 0;
  int         nrd    = 0;
  int         busy   = 0;
  initial begin
    drive_r = 8'h04;
    dq = 8'h00;
  end
  assign rb_oe_n = (busy == 0); // Only ever pulls low
  always @(posedge pclk) if (busy > 0) busy = busy - 1;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle) begin
      cmd_r = pins.dq_o;
      nbyte = 0;
      nrd = 0;
      if (pins.dq_o == 8'hff) busy = BUSY_CYC;
    end else if (!pins.ce_n && pins.ale) addr_r = pins.dq_o;
    else if (!pins.ce_n && cmd_r == 8'hef) begin
      if (nbyte == 0) par_r = pins.dq_o;
      nbyte++;
      if (nbyte == 4 && addr_r == 8'h10 && par_r inside {8'h02, 8'h04, 8'h06})
        drive_r = par_r;
      if (nbyte == 4) busy = BUSY_CYC / 4;
    end
  end
  always @(negedge pins.re_n) begin
    if (cmd_r == 8'h70) dq = {pins.wp_n, busy == 0, 6'h00};
    else dq = 8'((addr_r == 8'h40 ? SIG_ID : MAKER_ID) >> (8 * (5 - nrd)));
    nrd++;
  end
  always @(posedge pins.re_n) dq = ~dq; // Released: never the last value
endmodule : nand_dev_model
`default_nettype wire

// ==== testbench/nand_id_ctl_test.sv ====
// Self-checking bench for the NAND identification controller
`default_nettype none
`include "nand_ctl_defs.svh"
module nand_id_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nand_ctl_pkg::*;
  localparam logic [47:0] MAKER = 48'ha1b2c3d4e5f6; // Arbitrary value
  localparam logic [47:0] SIG   = 48'h5a6b7c8d9e0f; // Arbitrary value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, rb_oe_n;
  logic [7:0]  dev_dq, drive;
  nand_out_t   nand_out;
  nand_in_t    nand_in;
  int          miscompares = 0, n_checks = 0;
  assign nand_in = {nand_out.dq_oe_n ? dev_dq : nand_out.dq_o, rb_oe_n}; // Pull-up on ready/busy
  nand_id_ctl #(.RST_WAIT_CYC(200)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nand_in(nand_in), .nand_out(nand_out));
  nand_dev_model #(.MAKER_ID(MAKER), .SIG_ID(SIG)) u_dev (.pclk(pclk), .pins(nand_out),
    .dq(dev_dq), .rb_oe_n(rb_oe_n), .drive_r(drive));
  initial forever #5 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin miscompares++; complete_run(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask : rdchk
  task automatic go(input logic [2:0] op, input logic wp, input logic [7:0] a);
    logic [31:0] rd;
    logic        e;
    int          n = 0;
    apb(1'b1, `REG_CTRL, {16'h0, a, 3'b000, wp, op, 1'b1}, rd, e);
    do begin apb(1'b0, `REG_STATUS, 32'h0, rd, e); n++; end while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) begin miscompares++; complete_run(); end
  endtask : go
  task automatic t_before_init;
    logic [31:0] rd;
    logic        e;
    rdchk(`REG_DRIVE, 32'h04);
    apb(1'b0, 12'h020, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    go(`OP_DRIVE, 1'b1, 8'h00);
    rdchk(`REG_STATUS, 32'h0c);
    check({24'h0, drive}, 32'h04);
  endtask : t_before_init
  task automatic t_init;
    go(`OP_RESET, 1'b1, 8'h00);
    rdchk(`REG_STATUS, 32'h06);
    go(`OP_STATUS, 1'b1, 8'h00);
    rdchk(`REG_NAND_STAT, 32'hc0);
    rdchk(`REG_CTRL, 32'h16);
  endtask : t_init
  task automatic t_drive;
    logic [7:0] req[5] = '{8'h02, 8'h05, 8'h06, 8'h00, 8'h04};
    logic [7:0] exp[5] = '{8'h02, 8'h02, 8'h06, 8'h06, 8'h04};
    logic [31:0] rd;
    logic        e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `REG_DRIVE, {24'h0, req[i]}, rd, e);
      go(`OP_DRIVE, 1'b1, 8'h00);
      rdchk(`REG_DRIVE, {24'h0, exp[i]});
      check({24'h0, drive}, {24'h0, exp[i]});
    end
  endtask : t_drive
  task automatic t_id;
    logic [47:0] m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 1) ? SIG : MAKER;
      go(`OP_READ_ID, 1'b1, (i == 1) ? 8'h40 : 8'h00);
      rdchk(`REG_ID_LO, {m[23:16], m[31:24], m[39:32], m[47:40]});
      rdchk(`REG_ID_HI, {16'h0, m[7:0], m[15:8]});
    end
  endtask : t_id
  task automatic t_wp;
    go(`OP_STATUS, 1'b0, 8'h00);
    rdchk(`REG_NAND_STAT, 32'h40);
    rdchk(`REG_CTRL, 32'h06);
  endtask : t_wp
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_before_init();
    t_init();
    t_drive();
    t_id();
    t_wp();
    complete_run();
  end
endmodule : nand_id_ctl_test
`default_nettype wire
